// ### design/rcis_pkg.sv
// Package for the reference clock configuration and channel interrupt summary registers.
// Assumes a plain register port with read data one cycle after the read strobe.
package rcis_pkg;

   localparam int          RCIS_ADDR_W        = 12;
   localparam int          RCIS_DATA_W        = 8;
   localparam int          RCIS_NUM_CH        = 22;
   localparam int          RCIS_SEL_W         = 5;

   // Register offsets; the reference config register has no printed offset
   localparam logic [11:0] RCIS_OFS_REF2_CFG  = 12'h280;
   localparam logic [11:0] RCIS_OFS_SUM_LOW   = 12'h2C0;
   localparam logic [11:0] RCIS_OFS_SUM_MID   = 12'h300;
   localparam logic [11:0] RCIS_OFS_IRQ_STAT  = 12'h3E0;
   localparam logic [11:0] RCIS_OFS_IRQ_MASK  = 12'h3E4;

   // Field positions of the reference config register
   localparam int          RCIS_BIT_OE        = 6;
   localparam int          RCIS_BIT_RATE      = 5;

   // Reset values
   localparam logic [7:0]  RCIS_RST_REF2_CFG  = 8'h41;
   localparam logic [7:0]  RCIS_RST_SUM       = 8'h00;
   localparam logic [1:0]  RCIS_RST_IRQ       = 2'h0;

   // Highest channel code; codes above pick the external input
   localparam logic [4:0]  RCIS_SEL_MAX_CH    = 5'h15;

   // Summary events: bit 0 low group rises, bit 1 mid group rises
   localparam int          RCIS_EV_LOW        = 0;
   localparam int          RCIS_EV_MID        = 1;

   typedef struct packed {
      logic                oe;
      logic                rate_e1;
      logic [4:0]          sel;
   } rcis_ref_cfg_t;

   typedef struct packed {
      logic [11:0]         addr;
      logic [7:0]          wdata;
      logic                wr;
      logic                rd;
   } rcis_bus_req_t;

endpackage : rcis_pkg

// ### design/rcis_ch_summary.sv
// Per-channel interrupt summary: OR of the enabled pending flags of one channel.
// Assumes flag and enable vectors synchronous to ref_clk.
`timescale 1ns/100ps
module rcis_ch_summary #(
   parameter int SRC_N = 8
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // Channel sources
   input  wire logic [SRC_N-1:0] src_pend,
   input  wire logic [SRC_N-1:0] src_en,
   // Summary
   output logic                  summary
);
   import rcis_pkg::*;

   typedef struct packed {
      logic sum;
   } rcis_sum_state_t;

   rcis_sum_state_t st_reg;
   rcis_sum_state_t st_next;
   logic            any_pend;

   // Elaboration check on the source count
   if (SRC_N < 1)
   begin : g_bad_param
      $error("SRC_N must be at least 1");
   end

   assign any_pend = |(src_pend & src_en);

   always_comb
   begin
      st_next     = st_reg;
      st_next.sum = any_pend;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign summary = st_reg.sum;

   AST_SUM_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(rst_n) |-> summary == $past(any_pend))
      else $error("summary does not follow enabled pending flags");

endmodule : rcis_ch_summary

// ### design/rcis_regs.sv
// Reference clock source configuration and channel interrupt summary registers.
// Assumes a register port master that never overlaps strobes and channel flags on ref_clk.
`timescale 1ns/100ps
module rcis_regs #(
   parameter int NUM_CH = 22,
   parameter int SRC_N  = 8
) (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   // Register port
   input  wire logic [11:0]           reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [7:0]                 reg_rdata,
   // Channel interrupt sources, SRC_N per channel
   input  wire logic [NUM_CH*SRC_N-1:0] ch_irq_pend,
   input  wire logic [NUM_CH*SRC_N-1:0] ch_irq_en,
   // Clock sources
   input  wire logic [NUM_CH-1:0]     ch_rec_clk,
   input  wire logic                  ext_clk_in,
   // Second reference output pin and external input rate type
   output logic                       second_reference_output_o,
   output logic                       second_reference_output_oe,
   output logic                       external_input_rate_type,
   // Interrupt
   output logic                       irq
);
   import rcis_pkg::*;

   typedef struct packed {
      rcis_ref_cfg_t cfg;
      logic [7:0]    rdata;
      logic [1:0]    stat;
      logic [1:0]    mask;
      logic [1:0]    low_any_d;
      logic          ref_out;
   } rcis_regs_state_t;

   rcis_regs_state_t st_reg;
   rcis_regs_state_t st_next;

   logic [NUM_CH-1:0] ch_sum;
   logic [7:0]        channel_irq_flags_1_to_8;
   logic [7:0]        channel_irq_flags_9_to_16;
   logic [1:0]        ev;
   logic              src_clk;

   // Elaboration check: the mapped summaries and the source decoder need all channels
   if (NUM_CH != RCIS_NUM_CH || SRC_N < 1)
   begin : g_bad_param
      $error("NUM_CH must be 22 and SRC_N at least 1");
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ch
         rcis_ch_summary #(
            .SRC_N (SRC_N)
         ) u_sum (
            .ref_clk  (ref_clk),
            .rst_n    (rst_n),
            .src_pend (ch_irq_pend[g*SRC_N +: SRC_N]),
            .src_en   (ch_irq_en[g*SRC_N +: SRC_N]),
            .summary  (ch_sum[g])
         );
      end
   endgenerate

   assign channel_irq_flags_1_to_8  = ch_sum[8:1];
   assign channel_irq_flags_9_to_16 = ch_sum[16:9];

   // Rising of either summary group is an event
   assign ev[RCIS_EV_LOW] = (|channel_irq_flags_1_to_8) & ~st_reg.low_any_d[RCIS_EV_LOW];
   assign ev[RCIS_EV_MID] = (|channel_irq_flags_9_to_16) & ~st_reg.low_any_d[RCIS_EV_MID];

   // Source selection
   always_comb
   begin
      if (st_reg.cfg.sel <= RCIS_SEL_MAX_CH)
      begin
         src_clk = ch_rec_clk[st_reg.cfg.sel];
      end
      else
      begin
         src_clk = ext_clk_in;
      end
   end

   always_comb
   begin
      st_next = st_reg;
      st_next.low_any_d = {|channel_irq_flags_9_to_16, |channel_irq_flags_1_to_8};
      st_next.ref_out   = src_clk;
      st_next.rdata     = RCIS_RST_SUM;
      if (reg_wr)
      begin
         if (reg_addr == RCIS_OFS_REF2_CFG)
         begin
            st_next.cfg.oe      = reg_wdata[RCIS_BIT_OE];
            st_next.cfg.rate_e1 = reg_wdata[RCIS_BIT_RATE];
            st_next.cfg.sel     = reg_wdata[RCIS_SEL_W-1:0];
         end
         else if (reg_addr == RCIS_OFS_IRQ_STAT)
         begin
            st_next.stat = st_reg.stat & ~reg_wdata[1:0];
         end
         else if (reg_addr == RCIS_OFS_IRQ_MASK)
         begin
            st_next.mask = reg_wdata[1:0];
         end
      end
      // Set wins over a simultaneous clear
      st_next.stat = st_next.stat | ev;
      if (reg_rd)
      begin
         if (reg_addr == RCIS_OFS_REF2_CFG)
         begin
            st_next.rdata = {1'b0, st_reg.cfg.oe, st_reg.cfg.rate_e1, st_reg.cfg.sel};
         end
         else if (reg_addr == RCIS_OFS_SUM_LOW)
         begin
            st_next.rdata = channel_irq_flags_1_to_8;
         end
         else if (reg_addr == RCIS_OFS_SUM_MID)
         begin
            st_next.rdata = channel_irq_flags_9_to_16;
         end
         else if (reg_addr == RCIS_OFS_IRQ_STAT)
         begin
            st_next.rdata = {6'h00, st_reg.stat};
         end
         else if (reg_addr == RCIS_OFS_IRQ_MASK)
         begin
            st_next.rdata = {6'h00, st_reg.mask};
         end
         else
         begin
            st_next.rdata = RCIS_RST_SUM;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         st_reg.cfg       <= RCIS_RST_REF2_CFG[6:0];
         st_reg.rdata     <= RCIS_RST_SUM;
         st_reg.stat      <= RCIS_RST_IRQ;
         st_reg.mask      <= RCIS_RST_IRQ;
         st_reg.low_any_d <= RCIS_RST_IRQ;
         st_reg.ref_out   <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata                  = st_reg.rdata;
   assign second_reference_output_o  = st_reg.ref_out;
   assign second_reference_output_oe = st_reg.cfg.oe;
   assign external_input_rate_type   = st_reg.cfg.rate_e1;
   assign irq                        = |(st_reg.stat & st_reg.mask);

   // Bus request shapes shared by the properties below
   sequence s_cfg_write_ext;
      reg_wr && reg_addr == RCIS_OFS_REF2_CFG && reg_wdata[RCIS_SEL_W-1:0] > RCIS_SEL_MAX_CH;
   endsequence

   sequence s_cfg_read;
      reg_rd && reg_addr == RCIS_OFS_REF2_CFG;
   endsequence

   sequence s_stat_clear;
      reg_wr && reg_addr == RCIS_OFS_IRQ_STAT;
   endsequence

   sequence s_mask_write;
      reg_wr && reg_addr == RCIS_OFS_IRQ_MASK;
   endsequence

   AST_OE_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == RCIS_OFS_REF2_CFG && !reg_wdata[RCIS_BIT_OE]) |=> !second_reference_output_oe)
      else $error("output enable not cleared by write");

   AST_OE_ON: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == RCIS_OFS_REF2_CFG && reg_wdata[RCIS_BIT_OE]) |=> second_reference_output_oe)
      else $error("output enable not set by write");

   AST_OE_RESET: assert property (@(posedge ref_clk)
      $rose(rst_n) |-> second_reference_output_oe && !external_input_rate_type)
      else $error("reset value of config wrong");

   AST_RATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == RCIS_OFS_REF2_CFG) |=> external_input_rate_type == $past(reg_wdata[RCIS_BIT_RATE]))
      else $error("rate type bit not stored");

   AST_SEL_CH: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.cfg.sel <= RCIS_SEL_MAX_CH) |=> second_reference_output_o == $past(ch_rec_clk[st_reg.cfg.sel]))
      else $error("channel clock not routed");

   AST_SEL_EXT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_cfg_write_ext |=> ##1 (second_reference_output_o == $past(ext_clk_in)))
      else $error("external clock not routed");

   AST_RD_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == RCIS_OFS_SUM_LOW) |=> reg_rdata == $past(ch_sum[8:1]))
      else $error("low summary read wrong");

   AST_RD_MID: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == RCIS_OFS_SUM_MID) |=> reg_rdata == $past(ch_sum[16:9]))
      else $error("mid summary read wrong");

   AST_SUM_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (|(ch_irq_pend[SRC_N +: SRC_N] & ch_irq_en[SRC_N +: SRC_N])) |=> ch_sum[1])
      else $error("channel 1 summary not set");

   AST_SUM_CLR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(|(ch_irq_pend[SRC_N +: SRC_N] & ch_irq_en[SRC_N +: SRC_N])) |=> !ch_sum[1])
      else $error("channel 1 summary not cleared");

   AST_SUM8_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (|(ch_irq_pend[8*SRC_N +: SRC_N] & ch_irq_en[8*SRC_N +: SRC_N])) |=> channel_irq_flags_1_to_8[7])
      else $error("channel 8 summary not set");

   AST_SUM16_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (|(ch_irq_pend[16*SRC_N +: SRC_N] & ch_irq_en[16*SRC_N +: SRC_N])) |=> channel_irq_flags_9_to_16[7])
      else $error("channel 16 summary not set");

   AST_SUM16_CLR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(|(ch_irq_pend[16*SRC_N +: SRC_N] & ch_irq_en[16*SRC_N +: SRC_N])) |=> !channel_irq_flags_9_to_16[7])
      else $error("channel 16 summary not cleared");

   // Register read-back, idle read data, config hold and reset source selection
   AST_RD_CFG: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_cfg_read |=> reg_rdata == {1'b0, $past(st_reg.cfg)})
      else $error("config read-back wrong");

   AST_RD_STAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == RCIS_OFS_IRQ_STAT) |=> reg_rdata == {6'h00, $past(st_reg.stat)})
      else $error("status read-back wrong");

   AST_RD_MASK: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == RCIS_OFS_IRQ_MASK) |=> reg_rdata == {6'h00, $past(st_reg.mask)})
      else $error("mask read-back wrong");

   AST_RD_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == RCIS_RST_SUM)
      else $error("read data not cleared after the read cycle");

   AST_SEL_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(reg_wr && reg_addr == RCIS_OFS_REF2_CFG) |=> $stable(st_reg.cfg))
      else $error("config changed without a write");

   AST_SEL_RESET: assert property (@(posedge ref_clk)
      $rose(rst_n) |-> st_reg.cfg.sel == RCIS_RST_REF2_CFG[RCIS_SEL_W-1:0])
      else $error("reset source selection wrong");

   // Interrupt status, mask and output
   AST_STAT_SET_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(|channel_irq_flags_1_to_8) |=> st_reg.stat[RCIS_EV_LOW])
      else $error("low group event not latched");

   AST_STAT_SET_MID: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(|channel_irq_flags_9_to_16) |=> st_reg.stat[RCIS_EV_MID])
      else $error("mid group event not latched");

   AST_STAT_W1C: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_stat_clear ##0 (reg_wdata[RCIS_EV_LOW] && !$rose(|channel_irq_flags_1_to_8))
      |=> !st_reg.stat[RCIS_EV_LOW])
      else $error("low group status not cleared by writing one");

   AST_STAT_SET_WINS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_stat_clear ##0 $rose(|channel_irq_flags_1_to_8) |=> st_reg.stat[RCIS_EV_LOW])
      else $error("clear won over a simultaneous event");

   AST_STAT_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.stat[RCIS_EV_MID] && !(reg_wr && reg_addr == RCIS_OFS_IRQ_STAT)) |=> st_reg.stat[RCIS_EV_MID])
      else $error("mid group status dropped without a clear");

   AST_MASK_WR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_mask_write |=> st_reg.mask == $past(reg_wdata[RCIS_EV_MID:RCIS_EV_LOW]))
      else $error("mask not stored");

   AST_IRQ_ON: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.stat[RCIS_EV_MID] && st_reg.mask[RCIS_EV_MID]) |-> irq)
      else $error("interrupt low while an unmasked status bit is set");

   AST_IRQ_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!(st_reg.stat[RCIS_EV_LOW] && st_reg.mask[RCIS_EV_LOW]) && !(st_reg.stat[RCIS_EV_MID] && st_reg.mask[RCIS_EV_MID]))
      |-> !irq)
      else $error("interrupt high with no unmasked status bit");

endmodule : rcis_regs

// ### dv/rcis_board_model.sv
// Board model: feeds the recovered and external clocks, resolves the reference pin.
// Assumes a board pull-up on the second reference trace.
`timescale 1ns/100ps
module rcis_board_model (
   // Clock
   input  wire logic        ref_clk,
   // Clock sources
   output logic [21:0]      ch_rec_clk,
   output logic             ext_clk_in,
   // Reference pin
   input  wire logic        pin_o,
   input  wire logic        pin_oe,
   output logic             pin_level
);
   // New pattern each cycle so a stale selection shows
   initial
   begin
      ch_rec_clk = 22'h0;
      ext_clk_in = 1'b0;
      forever
      begin
         @(posedge ref_clk);
         ch_rec_clk <= 22'($urandom);
         ext_clk_in <= 1'($urandom);
      end
   end
   // Pull-up while the device releases the pin
   assign pin_level = pin_oe ? pin_o : 1'b1;
endmodule : rcis_board_model

// ### dv/tb_top.sv
// Testbench for the reference clock config and channel interrupt summary registers.
// Assumes rcis_pkg, rcis_regs and the board model are compiled first.
`timescale 1ns/100ps
module tb_top;
   import rcis_pkg::*;
   logic                     ref_clk;
   logic                     rst_n;
   logic [11:0]              reg_addr;
   logic [7:0]               reg_wdata;
   logic                     reg_wr;
   logic                     reg_rd;
   logic [7:0]               reg_rdata;
   logic [RCIS_NUM_CH*8-1:0] pend;
   logic [RCIS_NUM_CH*8-1:0] en;
   logic [21:0]              rec_clk;
   logic                     ext_clk;
   logic                     ref_o;
   logic                     ref_oe;
   logic                     rate_type;
   logic                     irq;
   logic                     pin_level;
   logic [7:0]               cfg;
   logic                     prev_src;
   int                       errors;
   int                       tests_run;

   rcis_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch_irq_pend(pend), .ch_irq_en(en),
      .ch_rec_clk(rec_clk), .ext_clk_in(ext_clk), .second_reference_output_o(ref_o),
      .second_reference_output_oe(ref_oe), .external_input_rate_type(rate_type), .irq(irq));
   rcis_board_model board (.ref_clk(ref_clk), .ch_rec_clk(rec_clk), .ext_clk_in(ext_clk),
      .pin_o(ref_o), .pin_oe(ref_oe), .pin_level(pin_level));

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", name, exp, got);
         errors++;
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd_chk(input string name, input logic [11:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      @(negedge ref_clk);
      chk(name, exp, reg_rdata);
   endtask : rd_chk

   // Output follows the source seen one edge earlier
   task automatic src_chk(input logic [4:0] sel);
      repeat (2) @(negedge ref_clk);
      repeat (4)
      begin
         prev_src = (sel > 5'h15) ? ext_clk : rec_clk[sel];
         @(negedge ref_clk);
         chk("ref_out", {7'h00, prev_src}, {7'h00, ref_o});
      end
   endtask : src_chk

   function automatic logic [7:0] sum_exp(input int base);
      logic [7:0] r;
      for (int i = 0; i < 8; i++)
         r[i] = |(pend[(base+i)*8+:8] & en[(base+i)*8+:8]);
      return r;
   endfunction : sum_exp

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   initial
   begin
      #2000000;
      errors++;
      stop_test();
   end

   initial
   begin
      rst_n = 1'b0; reg_addr = 12'h000; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
      pend = '0; en = '0; errors = 0; tests_run = 0;
      void'($urandom(32'hC824));
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_chk("ref_cfg", RCIS_OFS_REF2_CFG, 8'h41);
      chk("rate", 8'h00, {7'h00, rate_type});
      chk("oe", 8'h01, {7'h00, ref_oe});
      rd_chk("sum_low", RCIS_OFS_SUM_LOW, 8'h00);
      rd_chk("sum_mid", RCIS_OFS_SUM_MID, 8'h00);
      rd_chk("unmapped", 12'h123, 8'h00);
      for (int c = 0; c < 32; c++)
      begin
         cfg = {1'b0, 2'($urandom), 5'(c)};
         wr(RCIS_OFS_REF2_CFG, cfg);
         src_chk(5'(c));
         chk("oe", {7'h00, cfg[6]}, {7'h00, ref_oe});
         chk("rate", {7'h00, cfg[5]}, {7'h00, rate_type});
         if (!cfg[6])
            chk("pin_idle", 8'h01, {7'h00, pin_level});
         else
            chk("pin_drive", {7'h00, ref_o}, {7'h00, pin_level});
         rd_chk("ref_cfg", RCIS_OFS_REF2_CFG, cfg);
      end
      for (int k = 0; k < 24; k++)
      begin
         @(posedge ref_clk);
         for (int c = 0; c < RCIS_NUM_CH; c++)
         begin
            pend[c*8+:8] <= (k % 4 == 0) ? 8'h00 : 8'($urandom) & 8'($urandom) & 8'($urandom);
            en[c*8+:8]   <= (k % 4 == 1) ? 8'h00 : 8'($urandom);
         end
         repeat (2) @(posedge ref_clk);
         rd_chk("sum_low", RCIS_OFS_SUM_LOW, sum_exp(1));
         rd_chk("sum_mid", RCIS_OFS_SUM_MID, sum_exp(9));
      end
      @(posedge ref_clk);
      pend <= '0;
      repeat (3) @(posedge ref_clk);
      wr(RCIS_OFS_IRQ_STAT, 8'h03);
      wr(RCIS_OFS_IRQ_MASK, 8'h03);
      rd_chk("irq_stat", RCIS_OFS_IRQ_STAT, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      @(posedge ref_clk);
      pend[9*8+2] <= 1'b1;
      en[9*8+:8]  <= 8'hFF;
      repeat (3) @(posedge ref_clk);
      rd_chk("sum_mid", RCIS_OFS_SUM_MID, 8'h01);
      rd_chk("irq_stat", RCIS_OFS_IRQ_STAT, 8'h02);
      chk("irq", 8'h01, {7'h00, irq});
      wr(RCIS_OFS_IRQ_MASK, 8'h01);
      @(negedge ref_clk);
      chk("irq_masked", 8'h00, {7'h00, irq});
      wr(RCIS_OFS_IRQ_MASK, 8'h02);
      @(negedge ref_clk);
      chk("irq", 8'h01, {7'h00, irq});
      wr(RCIS_OFS_IRQ_STAT, 8'h02);
      @(negedge ref_clk);
      chk("irq_cleared", 8'h00, {7'h00, irq});
      rd_chk("irq_stat", RCIS_OFS_IRQ_STAT, 8'h00);
      // Summaries ignore writes; a low group event meeting a clear stays set
      wr(RCIS_OFS_SUM_MID, 8'hFF);
      rd_chk("sum_mid_ro", RCIS_OFS_SUM_MID, 8'h01);
      wr(RCIS_OFS_IRQ_MASK, 8'h01);
      @(posedge ref_clk);
      pend[3*8+5] <= 1'b1;
      en[3*8+:8]  <= 8'h20;
      wr(RCIS_OFS_IRQ_STAT, 8'h01);
      rd_chk("irq_stat_set_wins", RCIS_OFS_IRQ_STAT, 8'h01);
      chk("irq_low", 8'h01, {7'h00, irq});
      rd_chk("sum_low", RCIS_OFS_SUM_LOW, 8'h04);
      stop_test();
   end
endmodule : tb_top
